/* design/ldm_decode.sv */
/*
 * Load/multiply slice instruction decoder with word and cycle sequencing.
 * Assumes the fetch path offers one word per cycle with a valid strobe,
 * holding a word while READY is low.
 */
`include "ldm_decode_consts.svh"

module ldm_decode (
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic [15:0] INSTR_WORD,
	input wire logic INSTR_VALID,
	output logic READY,
	output logic OP_VALID,
	output ldm_decode_pkg::ldm_op_t OP_CODE,
	output logic [7:0] OPERAND_LOW,
	output logic [2:0] AUX_REG_SELECT,
	output logic [8:0] PAGE_VALUE,
	output logic [15:0] SECOND_WORD,
	output logic [1:0] OP_WORDS,
	output logic [1:0] OP_CYCLES,
	output logic OP_UNKNOWN
);

	ldm_decode_pkg::ldm_state_t state_r;
	ldm_decode_pkg::ldm_op_t cls_op;
	ldm_decode_pkg::ldm_op_t pend_op_r;
	logic [1:0] cls_words;
	logic [1:0] cls_cycles;
	logic [1:0] pend_cycles_r;
	logic [1:0] busy_cnt_r;
	logic [15:0] first_word_r;
	logic take_first;
	logic take_second;

	ldm_word_class u_class (
		.word(INSTR_WORD),
		.op(cls_op),
		.words(cls_words),
		.cycles(cls_cycles)
	);

	// ****************************************************************
	// Handshake
	// ****************************************************************
	// Words are refused while a multi-cycle operation is still executing
	assign READY = (state_r != ldm_decode_pkg::LDM_ST_BUSY);
	assign take_first = INSTR_VALID && (state_r == ldm_decode_pkg::LDM_ST_FIRST);
	assign take_second = INSTR_VALID && (state_r == ldm_decode_pkg::LDM_ST_SECOND);

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			state_r <= ldm_decode_pkg::LDM_ST_FIRST;
			busy_cnt_r <= 2'h0;
		end else begin
			case (state_r)
				ldm_decode_pkg::LDM_ST_FIRST: begin
					if (take_first) begin
						if (cls_words == `LDM_WORDS_TWO) begin
							state_r <= ldm_decode_pkg::LDM_ST_SECOND;
						end else if (cls_cycles != `LDM_CYC_ONE) begin
							state_r <= ldm_decode_pkg::LDM_ST_BUSY;
							busy_cnt_r <= cls_cycles - `LDM_CYC_ONE;
						end
					end
				end
				ldm_decode_pkg::LDM_ST_SECOND: begin
					if (take_second) begin
						// The second word uses one of the cycles itself
						if (pend_cycles_r > `LDM_CYC_TWO) begin
							state_r <= ldm_decode_pkg::LDM_ST_BUSY;
							busy_cnt_r <= pend_cycles_r - `LDM_CYC_TWO;
						end else begin
							state_r <= ldm_decode_pkg::LDM_ST_FIRST;
						end
					end
				end
				ldm_decode_pkg::LDM_ST_BUSY: begin
					if (busy_cnt_r == `LDM_CYC_ONE) begin
						state_r <= ldm_decode_pkg::LDM_ST_FIRST;
					end
					busy_cnt_r <= busy_cnt_r - `LDM_CYC_ONE;
				end
				default: state_r <= ldm_decode_pkg::LDM_ST_FIRST;
			endcase
		end
	end

	// ****************************************************************
	// First-word capture for two-word forms
	// ****************************************************************
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			pend_op_r <= ldm_decode_pkg::LDM_OP_NONE;
			pend_cycles_r <= `LDM_CYC_ONE;
			first_word_r <= 16'h0000;
		end else if (take_first && cls_words == `LDM_WORDS_TWO) begin
			pend_op_r <= cls_op;
			pend_cycles_r <= cls_cycles;
			first_word_r <= INSTR_WORD;
		end
	end

	// ****************************************************************
	// Decoded outputs
	// ****************************************************************
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			OP_VALID <= 1'b0;
			OP_CODE <= ldm_decode_pkg::LDM_OP_NONE;
			OPERAND_LOW <= 8'h00;
			AUX_REG_SELECT <= 3'h0;
			PAGE_VALUE <= 9'h000;
			SECOND_WORD <= 16'h0000;
			OP_WORDS <= `LDM_WORDS_ONE;
			OP_CYCLES <= `LDM_CYC_ONE;
			OP_UNKNOWN <= 1'b0;
		end else begin
			OP_VALID <= 1'b0;
			OP_UNKNOWN <= 1'b0;
			if (take_first && cls_words == `LDM_WORDS_ONE) begin
				OP_VALID <= (cls_op != ldm_decode_pkg::LDM_OP_NONE);
				OP_UNKNOWN <= (cls_op == ldm_decode_pkg::LDM_OP_NONE);
				OP_CODE <= cls_op;
				OPERAND_LOW <= INSTR_WORD[7:0];
				// Short aux form selects in the upper byte, pointer form in the lower
				if (cls_op == ldm_decode_pkg::LDM_OP_SET_ARP) begin
					AUX_REG_SELECT <= INSTR_WORD[`LDM_LONG_SEL_MSB:0];
				end else begin
					AUX_REG_SELECT <= INSTR_WORD[`LDM_AUX_SEL_MSB:`LDM_AUX_SEL_LSB];
				end
				PAGE_VALUE <= {INSTR_WORD[`LDM_PAGE_HI_BIT], INSTR_WORD[7:0]};
				SECOND_WORD <= 16'h0000;
				OP_WORDS <= cls_words;
				OP_CYCLES <= cls_cycles;
			end else if (take_second) begin
				OP_VALID <= 1'b1;
				OP_CODE <= pend_op_r;
				OPERAND_LOW <= first_word_r[7:0];
				AUX_REG_SELECT <= first_word_r[`LDM_LONG_SEL_MSB:0];
				PAGE_VALUE <= 9'h000;
				SECOND_WORD <= INSTR_WORD;
				OP_WORDS <= `LDM_WORDS_TWO;
				OP_CYCLES <= pend_cycles_r;
			end
		end
	end

endmodule // ldm_decode

/* design/ldm_decode_consts.svh */
/*
 * Opcode patterns, masks, field positions and cycle counts for the
 * load/multiply slice decoder.
 * Assumes 16-bit instruction words, upper byte in bits 15..8.
 */
`ifndef LDM_DECODE_CONSTS_SVH
`define LDM_DECODE_CONSTS_SVH

// ****************************************************************
// Upper-byte, lower-byte and whole-word patterns
// ****************************************************************
`define LDM_UB_LOAD_ACC_IMM 8'hb9
`define LDM_UB_ZLO_LOAD_HI 8'h6a
`define LDM_UB_ZHI_LOAD_LO 8'h69
`define LDM_UB_LOAD_ACC_SHIFT_BY_T_OPERAND_REGISTER 8'h6b
`define LDM_UB_AUX_SHORT_MASK 8'hf8
`define LDM_UB_AUX_SHORT 8'hb0
`define LDM_UB_AUX_LONG 8'hbf
`define LDM_LB_AUX_LONG_MASK 8'hf8
`define LDM_LB_AUX_LONG 8'h08
`define LDM_UB_PAGE_MEM 8'h0d
`define LDM_UB_PAGE_IMM_MASK 8'hfe
`define LDM_UB_PAGE_IMM 8'hbc
`define LDM_UB_STATUS_ZERO 8'h0e
`define LDM_UB_STATUS_ONE 8'h0f
`define LDM_UB_LOAD_T_AND_ACCUMULATE 8'h70
`define LDM_UB_LOAD_T_ACC_MOVE 8'h72
`define LDM_UB_LOAD_T_PRODUCT_TO_ACC 8'h71
`define LDM_UB_LOAD_T_AND_SUBTRACT 8'h74
`define LDM_UB_PRODUCT_ACCUMULATE_MOVE 8'ha3
`define LDM_UB_ARP_SET 8'h8b
`define LDM_LB_ARP_SET_MASK 8'hf8
`define LDM_LB_ARP_SET 8'h88
`define LDM_UB_MULTIPLY 8'h54
`define LDM_UB_PRODUCT_THEN_ACCUMULATE 8'h50
`define LDM_UB_PRODUCT_THEN_SUBTRACT 8'h51
`define LDM_UB_EXPONENT_ALIGN_ACC 8'ha0
`define LDM_W_OR_HIGH_IMM 16'hbe82
`define LDM_W_COPY_PRODUCT_TO_ACC 16'hbe03

// ****************************************************************
// Field positions and widths
// ****************************************************************
`define LDM_AUX_SEL_LSB 8
`define LDM_AUX_SEL_MSB 10
`define LDM_LONG_SEL_MSB 2
`define LDM_PAGE_HI_BIT 8

// ****************************************************************
// Cycle and word counts
// ****************************************************************
`define LDM_CYC_ONE 2'h1
`define LDM_CYC_TWO 2'h2
`define LDM_CYC_THREE 2'h3
`define LDM_WORDS_ONE 2'h1
`define LDM_WORDS_TWO 2'h2

`endif

/* design/ldm_decode_pkg.sv */
/*
 * Types shared by the load/multiply slice decoder.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ldm_decode_pkg;

	typedef enum logic [4:0] {
		LDM_OP_NONE,
		LDM_OP_LOAD_ACC_IMM,
		LDM_OP_ZERO_ACC,
		LDM_OP_ZLO_LOAD_HI,
		LDM_OP_ZHI_LOAD_LO,
		LDM_OP_LOAD_ACC_SHIFT_BY_T_OPERAND_REGISTER,
		LDM_OP_LOAD_AUX_SHORT,
		LDM_OP_LOAD_AUX_REG_LONG,
		LDM_OP_SET_PAGE_POINTER_MEM,
		LDM_OP_SET_PAGE_POINTER_IMM,
		LDM_OP_LOAD_STATUS_WORD_ZERO,
		LDM_OP_LOAD_STATUS_WORD_ONE,
		LDM_OP_LOAD_T_AND_ACCUMULATE,
		LDM_OP_LOAD_T_ACC_MOVE,
		LDM_OP_LOAD_T_PRODUCT_TO_ACC,
		LDM_OP_LOAD_T_AND_SUBTRACT,
		LDM_OP_PRODUCT_ACCUMULATE_MOVE,
		LDM_OP_SET_ARP,
		LDM_OP_MULTIPLY,
		LDM_OP_PRODUCT_THEN_ACCUMULATE,
		LDM_OP_PRODUCT_THEN_SUBTRACT,
		LDM_OP_EXPONENT_ALIGN_ACC,
		LDM_OP_OR_HIGH_IMM,
		LDM_OP_COPY_PRODUCT_TO_ACC
	} ldm_op_t;

	typedef enum {
		LDM_ST_FIRST,
		LDM_ST_SECOND,
		LDM_ST_BUSY
	} ldm_state_t;

endpackage : ldm_decode_pkg

/* design/ldm_word_class.sv */
/*
 * Combinational classifier: maps a first instruction word onto an
 * operation code, word count and cycle count for this slice.
 * Assumes the caller registers the outputs.
 */
`include "ldm_decode_consts.svh"

module ldm_word_class (
	input wire logic [15:0] word,
	output ldm_decode_pkg::ldm_op_t op,
	output logic [1:0] words,
	output logic [1:0] cycles
);

	logic [7:0] ub;
	logic [7:0] lb;

	assign ub = word[15:8];
	assign lb = word[7:0];

	// ****************************************************************
	// Pattern match
	// ****************************************************************
	always_comb begin
		op = ldm_decode_pkg::LDM_OP_NONE;
		words = `LDM_WORDS_ONE;
		cycles = `LDM_CYC_ONE;
		if (word == `LDM_W_OR_HIGH_IMM) begin
			op = ldm_decode_pkg::LDM_OP_OR_HIGH_IMM;
			words = `LDM_WORDS_TWO;
			cycles = `LDM_CYC_TWO;
		end else if (word == `LDM_W_COPY_PRODUCT_TO_ACC) begin
			op = ldm_decode_pkg::LDM_OP_COPY_PRODUCT_TO_ACC;
		end else if (ub == `LDM_UB_AUX_LONG && (lb & `LDM_LB_AUX_LONG_MASK) == `LDM_LB_AUX_LONG) begin
			op = ldm_decode_pkg::LDM_OP_LOAD_AUX_REG_LONG;
			words = `LDM_WORDS_TWO;
			cycles = `LDM_CYC_TWO;
		end else if (ub == `LDM_UB_ARP_SET && (lb & `LDM_LB_ARP_SET_MASK) == `LDM_LB_ARP_SET) begin
			op = ldm_decode_pkg::LDM_OP_SET_ARP;
		end else if ((ub & `LDM_UB_AUX_SHORT_MASK) == `LDM_UB_AUX_SHORT) begin
			op = ldm_decode_pkg::LDM_OP_LOAD_AUX_SHORT;
			cycles = `LDM_CYC_TWO;
		end else if ((ub & `LDM_UB_PAGE_IMM_MASK) == `LDM_UB_PAGE_IMM) begin
			op = ldm_decode_pkg::LDM_OP_SET_PAGE_POINTER_IMM;
			cycles = `LDM_CYC_TWO;
		end else begin
			case (ub)
				`LDM_UB_LOAD_ACC_IMM: begin
					op = (lb == 8'h00) ? ldm_decode_pkg::LDM_OP_ZERO_ACC : ldm_decode_pkg::LDM_OP_LOAD_ACC_IMM;
				end
				`LDM_UB_ZLO_LOAD_HI: op = ldm_decode_pkg::LDM_OP_ZLO_LOAD_HI;
				`LDM_UB_ZHI_LOAD_LO: op = ldm_decode_pkg::LDM_OP_ZHI_LOAD_LO;
				`LDM_UB_LOAD_ACC_SHIFT_BY_T_OPERAND_REGISTER: op = ldm_decode_pkg::LDM_OP_LOAD_ACC_SHIFT_BY_T_OPERAND_REGISTER;
				`LDM_UB_PAGE_MEM: begin
					op = ldm_decode_pkg::LDM_OP_SET_PAGE_POINTER_MEM;
					cycles = `LDM_CYC_TWO;
				end
				`LDM_UB_STATUS_ZERO: begin
					op = ldm_decode_pkg::LDM_OP_LOAD_STATUS_WORD_ZERO;
					cycles = `LDM_CYC_TWO;
				end
				`LDM_UB_STATUS_ONE: begin
					op = ldm_decode_pkg::LDM_OP_LOAD_STATUS_WORD_ONE;
					cycles = `LDM_CYC_TWO;
				end
				`LDM_UB_LOAD_T_AND_ACCUMULATE: op = ldm_decode_pkg::LDM_OP_LOAD_T_AND_ACCUMULATE;
				`LDM_UB_LOAD_T_ACC_MOVE: op = ldm_decode_pkg::LDM_OP_LOAD_T_ACC_MOVE;
				`LDM_UB_LOAD_T_PRODUCT_TO_ACC: op = ldm_decode_pkg::LDM_OP_LOAD_T_PRODUCT_TO_ACC;
				`LDM_UB_LOAD_T_AND_SUBTRACT: op = ldm_decode_pkg::LDM_OP_LOAD_T_AND_SUBTRACT;
				`LDM_UB_PRODUCT_ACCUMULATE_MOVE: begin
					op = ldm_decode_pkg::LDM_OP_PRODUCT_ACCUMULATE_MOVE;
					words = `LDM_WORDS_TWO;
					cycles = `LDM_CYC_THREE;
				end
				`LDM_UB_MULTIPLY: op = ldm_decode_pkg::LDM_OP_MULTIPLY;
				`LDM_UB_PRODUCT_THEN_ACCUMULATE: op = ldm_decode_pkg::LDM_OP_PRODUCT_THEN_ACCUMULATE;
				`LDM_UB_PRODUCT_THEN_SUBTRACT: op = ldm_decode_pkg::LDM_OP_PRODUCT_THEN_SUBTRACT;
				`LDM_UB_EXPONENT_ALIGN_ACC: op = ldm_decode_pkg::LDM_OP_EXPONENT_ALIGN_ACC;
				default: op = ldm_decode_pkg::LDM_OP_NONE;
			endcase
		end
	end

endmodule // ldm_word_class

/* tb/ldm_decode_asserts.sv */
/*
 * Port-level checker for the load/multiply slice decoder.
 * Assumes only the decoder's own ports, single clock domain.
 */
module ldm_decode_asserts (
	input logic CLOCK,
	input logic RSTN,
	input logic [15:0] INSTR_WORD,
	input logic INSTR_VALID,
	input logic READY,
	input logic OP_VALID,
	input ldm_decode_pkg::ldm_op_t OP_CODE,
	input logic [7:0] OPERAND_LOW,
	input logic [2:0] AUX_REG_SELECT,
	input logic [8:0] PAGE_VALUE,
	input logic [15:0] SECOND_WORD,
	input logic [1:0] OP_WORDS,
	input logic [1:0] OP_CYCLES,
	input logic OP_UNKNOWN
);
	timeunit 1ns;
	timeprecision 100ps;
	// ********
	// Word tracking
	// ********
	logic sec_r;
	logic take;
	logic two_w;
	logic first_t;
	assign take = INSTR_VALID && READY;
	assign two_w = INSTR_WORD == 16'hbe82 || INSTR_WORD[15:3] == 13'h17e1 || INSTR_WORD[15:8] == 8'ha3;
	assign first_t = take && !sec_r;
	// Second word carries data, so it must never be classified itself
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN)
			sec_r <= 1'b0;
		else if (take)
			sec_r <= first_t && two_w;
	end
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RSTN);
	// ********
	// Properties
	// ********
	a_low_byte: assert property (OP_VALID && OP_WORDS == 2'h1 |->
		$past(take) && OPERAND_LOW == $past(INSTR_WORD[7:0])) else $error("low byte not passed");
	a_short_stall: assert property (OP_VALID && OP_WORDS == 2'h1 && OP_CYCLES == 2'h2 |-> !READY ##1 READY)
		else $error("two-cycle stall wrong");
	a_long_stall: assert property (OP_VALID && OP_CYCLES == 2'h3 |-> !READY ##1 READY)
		else $error("three-cycle stall wrong");
	a_first_silent: assert property (first_t && two_w |=> !OP_VALID && !OP_UNKNOWN)
		else $error("output on first word");
	a_second_taken: assert property (take && sec_r |=> OP_VALID && OP_WORDS == 2'h2 &&
		SECOND_WORD == $past(INSTR_WORD)) else $error("second word not presented");
	a_t_accum: assert property (first_t && INSTR_WORD[15:8] == 8'h70 |=>
		OP_VALID && OP_CODE == ldm_decode_pkg::LDM_OP_LOAD_T_AND_ACCUMULATE) else $error("t accumulate");
	a_aux_short: assert property (first_t && INSTR_WORD[15:11] == 5'h16 |=>
		OP_CODE == ldm_decode_pkg::LDM_OP_LOAD_AUX_SHORT && AUX_REG_SELECT == $past(INSTR_WORD[10:8]))
		else $error("aux short load");
	a_page_imm: assert property (first_t && INSTR_WORD[15:9] == 7'h5e |=>
		OP_CODE == ldm_decode_pkg::LDM_OP_SET_PAGE_POINTER_IMM && PAGE_VALUE == $past(INSTR_WORD[8:0]))
		else $error("page immediate");
	a_single_ready: assert property (OP_VALID && OP_CYCLES == 2'h1 |-> READY)
		else $error("one-cycle op stalled");
	c_long: cover property (OP_VALID && OP_CYCLES == 2'h3);
	c_pair: cover property (take && sec_r);
	c_unknown: cover property (OP_UNKNOWN);
endmodule // ldm_decode_asserts

bind ldm_decode ldm_decode_asserts i_chk (.CLOCK(CLOCK), .RSTN(RSTN), .INSTR_WORD(INSTR_WORD),
	.INSTR_VALID(INSTR_VALID), .READY(READY), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
	.OPERAND_LOW(OPERAND_LOW), .AUX_REG_SELECT(AUX_REG_SELECT), .PAGE_VALUE(PAGE_VALUE),
	.SECOND_WORD(SECOND_WORD), .OP_WORDS(OP_WORDS), .OP_CYCLES(OP_CYCLES), .OP_UNKNOWN(OP_UNKNOWN));

/* tb/ldm_fetch_model.sv */
/*
 * Fetch-side model: offers one instruction word at a time, holds it until taken.
 * Assumes the bench raises go with nw for one edge per word.
 */
module ldm_fetch_model (
	input logic clk,
	input logic rstn,
	input logic ready,
	input logic go,
	input logic [15:0] nw,
	output logic [15:0] word,
	output logic valid,
	output logic taken
);
	timeunit 1ns;
	timeprecision 100ps;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			valid <= 1'b0;
			word <= 16'h0;
			taken <= 1'b0;
		end else begin
			taken <= valid && ready;
			if (go) begin
				word <= nw;
				valid <= 1'b1;
			end else if (valid && ready) begin
				// Released bus shows junk so a stale word never matches
				valid <= 1'b0;
				word <= ~word;
			end
		end
	end
endmodule // ldm_fetch_model

/* tb/tb_dsp_load_multiply_opcode_decode.sv */
/*
 * Self-checking bench for the load/multiply slice decoder.
 * Assumes the fetch model stands in for the program fetch path.
 */
module tb_dsp_load_multiply_opcode_decode;
	timeunit 1ns;
	timeprecision 100ps;
	logic CLOCK = 1'b0;
	logic RSTN = 1'b1;
	logic INSTR_VALID, READY, OP_VALID, OP_UNKNOWN, go, taken;
	logic [15:0] INSTR_WORD, SECOND_WORD, nw;
	ldm_decode_pkg::ldm_op_t OP_CODE;
	logic [7:0] OPERAND_LOW;
	logic [2:0] AUX_REG_SELECT;
	logic [8:0] PAGE_VALUE;
	logic [1:0] OP_WORDS, OP_CYCLES;
	int err_total = 0;
	int checks = 0;
	// Word, expected code in declaration order, expected cycles
	logic [31:0] tbl [21] = '{32'hb9550101, 32'hb9000201, 32'h6a120301, 32'h69340401, 32'h6b560501,
		32'hb5a70602, 32'h0d110802, 32'hbd220902, 32'hbc050902, 32'h0e330a02, 32'h0f440b02, 32'h70120c01,
		32'h72550d01, 32'h71660e01, 32'h74770f01, 32'h8b8d1101, 32'h54881201, 32'h50991301, 32'h51aa1401,
		32'ha0bb1501, 32'hbe031701};

	ldm_decode i_dut (.CLOCK(CLOCK), .RSTN(RSTN), .INSTR_WORD(INSTR_WORD), .INSTR_VALID(INSTR_VALID),
		.READY(READY), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .OPERAND_LOW(OPERAND_LOW),
		.AUX_REG_SELECT(AUX_REG_SELECT), .PAGE_VALUE(PAGE_VALUE), .SECOND_WORD(SECOND_WORD),
		.OP_WORDS(OP_WORDS), .OP_CYCLES(OP_CYCLES), .OP_UNKNOWN(OP_UNKNOWN));
	ldm_fetch_model i_fetch (.clk(CLOCK), .rstn(RSTN), .ready(READY), .go(go), .nw(nw),
		.word(INSTR_WORD), .valid(INSTR_VALID), .taken(taken));

	initial begin
		forever #50 CLOCK = ~CLOCK;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Hands one word to the fetch model; returns just after the taking edge
	task automatic dec(input logic [15:0] w);
		int n;
		nw = w;
		go = 1'b1;
		@(posedge CLOCK);
		#1 go = 1'b0;
		n = 0;
		while (taken !== 1'b1 && n < 20) begin
			@(posedge CLOCK);
			#1 n++;
		end
		if (taken !== 1'b1)
			chk(16'h0, 16'h1);
	endtask

	task automatic t_table();
		logic [15:0] w;
		for (int i = 0; i < 21; i++) begin
			w = tbl[i][31:16];
			dec(w);
			chk(16'(OP_VALID), 16'h1);
			chk(16'(OP_CODE), 16'(tbl[i][15:8]));
			chk(16'(OP_CYCLES), 16'(tbl[i][7:0]));
			chk(16'(OPERAND_LOW), 16'(w[7:0]));
			chk(16'(READY), 16'(tbl[i][7:0] == 8'h1));
		end
		$display("table test done");
	endtask

	task automatic t_fields();
		dec(16'hb5a7);
		chk(16'(AUX_REG_SELECT), 16'h5);
		dec(16'hbd22);
		chk(16'(PAGE_VALUE), 16'h0122);
		dec(16'h8b8e);
		chk(16'(AUX_REG_SELECT), 16'h6);
		$display("field test done");
	endtask

	task automatic t_pairs();
		dec(16'hbe82);
		chk(16'(OP_VALID), 16'h0);
		dec(16'h1234);
		chk(16'(OP_CODE), 16'h16);
		chk(SECOND_WORD, 16'h1234);
		chk(16'({OP_WORDS, OP_CYCLES}), 16'ha);
		dec(16'hbf0b);
		dec(16'habcd);
		chk(16'(OP_CODE), 16'h7);
		chk(16'(AUX_REG_SELECT), 16'h3);
		chk(SECOND_WORD, 16'habcd);
		dec(16'ha3ff);
		dec(16'h0456);
		chk(16'(OP_CODE), 16'h10);
		chk(16'({OP_WORDS, OP_CYCLES}), 16'hb);
		chk(16'(READY), 16'h0);
		@(posedge CLOCK);
		#1 chk(16'(READY), 16'h1);
		$display("pair test done");
	endtask

	task automatic t_unknown();
		dec(16'h8b00);
		chk(16'({OP_VALID, OP_UNKNOWN}), 16'h1);
		dec(16'h5500);
		chk(16'({OP_VALID, OP_UNKNOWN}), 16'h1);
		$display("unknown test done");
	endtask

	// Reset while a first word waits for its partner; the next word must start afresh
	task automatic t_reset();
		dec(16'hbe82);
		RSTN = 1'b0;
		repeat (2) @(posedge CLOCK);
		chk(16'({READY, OP_VALID, OP_UNKNOWN}), 16'h4);
		#1 RSTN = 1'b1;
		dec(16'h7012);
		chk(16'({OP_VALID, OP_CODE}), 16'h2c);
		chk(16'(OPERAND_LOW), 16'h12);
		$display("reset test done");
	endtask

	initial begin
		#200000;
		err_total++;
		complete_run();
	end

	initial begin
		nw = 16'h0;
		go = 1'b0;
		RSTN = 1'b0;
		repeat (12) @(posedge CLOCK);
		chk(16'({READY, OP_VALID, OP_UNKNOWN}), 16'h4);
		#1 RSTN = 1'b1;
		t_table();
		t_fields();
		t_pairs();
		t_unknown();
		t_reset();
		complete_run();
	end
endmodule // tb_dsp_load_multiply_opcode_decode
